// [core/fspg_top.sv]
// Flash command status flags, sequence guard and protection register.
// Assumes an APB master on core_clk and an external sequencer that
// takes launched commands and reports activity and verify results.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module fspg_top (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              special_mode,
    input  wire logic              flash_wr,
    input  wire logic [15:0]       flash_addr,
    input  wire logic [15:0]       flash_data,
    input  wire logic              cpu_stop,
    input  wire logic              seq_take,
    input  wire logic              seq_active,
    input  wire logic              verify_blank,
    input  wire logic              verify_fail,
    output logic                   launch,
    output fspg_pkg::fspg_cmd_t    launch_cmd,
    output logic [7:0]             prot_active,
    output logic                   irq
);
    logic                 buffer_empty_flag_q;
    logic                 command_complete_flag_q;
    logic                 protection_violation_flag_q;
    logic                 access_error_flag_q;
    logic                 blank_q;
    logic                 fail_q;
    logic                 buffer_empty_irq_enable_q;
    logic                 complete_irq_enable_q;
    logic                 div_loaded_q;
    logic [7:0]           clock_divider_register_q;
    logic [7:0]           protection_register_q;
    logic [7:0]           prot_d;
    fspg_pkg::fspg_seq_t  seq_q;
    fspg_pkg::fspg_seq_t  seq_d;
    fspg_pkg::fspg_cmd_t  buf_q;
    logic [31:0]          prdata_q;

    logic                 wr;
    logic                 map_ok;
    logic [3:0]           idx;
    logic                 wr_div;
    logic                 wr_cfg;
    logic                 wr_prot;
    logic                 wr_st;
    logic                 wr_cmd;
    logic                 prot_ok;
    logic                 prot_hit;
    logic                 code_ok;
    logic                 flash_ok;
    logic                 seq_err;
    logic                 go;
    logic                 blocked;
    logic                 div_err;
    logic                 viol_set;
    logic                 stop_err;
    logic                 err_set;
    logic                 done;
    logic [7:0]           status_rd;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_q;

    assign idx    = paddr[5:2];
    assign map_ok = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
    assign wr     = psel && penable && pwrite && map_ok;
    assign wr_div  = wr && (idx == fspg_pkg::IDX_CLKDIV);
    assign wr_cfg  = wr && (idx == fspg_pkg::IDX_CONFIG);
    assign wr_prot = wr && (idx == fspg_pkg::IDX_PROT);
    assign wr_st   = wr && (idx == fspg_pkg::IDX_STATUS);
    assign wr_cmd  = wr && (idx == fspg_pkg::IDX_COMMAND);

    fspg_prot_check u_prot (
        .cur   (protection_register_q),
        .req   (pwdata[7:0]),
        .addr  (buf_q.addr),
        .allow (prot_ok),
        .hit   (prot_hit)
    );

    assign code_ok = (pwdata[7:0] == fspg_pkg::CMD_VERIFY)
                  || (pwdata[7:0] == fspg_pkg::CMD_PROG)
                  || (pwdata[7:0] == fspg_pkg::CMD_SECT)
                  || (pwdata[7:0] == fspg_pkg::CMD_MASS); // [RL21]

    localparam int ST_EMPTY_B = fspg_pkg::ST_EMPTY;

    // Sequence step events
    assign flash_ok = flash_wr && (seq_q == fspg_pkg::SQ_IDLE)
                   && !flash_addr[0] && buffer_empty_flag_q; // [RL20]
    assign seq_err =
        (flash_wr && (seq_q != fspg_pkg::SQ_IDLE
                      || (flash_addr[0] && buffer_empty_flag_q)))
        || (wr_cmd && (seq_q != fspg_pkg::SQ_ADDR || !code_ok)) // [RL21]
        || ((wr_div || wr_cfg || wr_prot) && seq_q != fspg_pkg::SQ_IDLE)
        || (wr_st && !pwdata[ST_EMPTY_B]
            && seq_q != fspg_pkg::SQ_IDLE) // [RL9]
        || (wr_st && pwdata[ST_EMPTY_B]
            && seq_q == fspg_pkg::SQ_ADDR); // [RL15]

    assign go = wr_st && pwdata[ST_EMPTY_B] && (seq_q == fspg_pkg::SQ_CMD);
    assign blocked = protection_violation_flag_q // [RL14]
                  || access_error_flag_q         // [RL16]
                  || (special_mode && fail_q);   // [RL18]
    assign div_err  = go && !blocked && !div_loaded_q; // [RL22]
    assign viol_set = go && !blocked && div_loaded_q && prot_hit
                   && (buf_q.code != fspg_pkg::CMD_VERIFY); // [RL13]
    assign launch   = go && !blocked && div_loaded_q && !viol_set;
    assign stop_err = cpu_stop && !command_complete_flag_q; // [RL15]
    assign err_set  = seq_err || div_err || stop_err; // [RL15]

    always_comb begin
        seq_d = seq_q;
        if (err_set || go || viol_set) begin
            seq_d = fspg_pkg::SQ_IDLE;
        end else if (flash_ok) begin
            seq_d = fspg_pkg::SQ_ADDR;
        end else if (wr_cmd) begin
            seq_d = fspg_pkg::SQ_CMD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            seq_q <= fspg_pkg::SQ_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    // Address, data and command buffer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            buf_q <= '0;
        end else if (flash_ok) begin
            buf_q.addr <= flash_addr;
            buf_q.data <= flash_data;
        end else if (wr_cmd && seq_q == fspg_pkg::SQ_ADDR && code_ok) begin
            buf_q.code <= pwdata[7:0];
        end
    end
    assign launch_cmd = buf_q;

    // Buffer empty: cleared by launch, set when the sequencer takes it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            buffer_empty_flag_q <= 1'b1;
        end else if (seq_take) begin
            buffer_empty_flag_q <= 1'b1;
        end else if (launch) begin
            buffer_empty_flag_q <= 1'b0; // [RL8]
        end
    end

    // Complete only once nothing is buffered and nothing runs
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            command_complete_flag_q <= 1'b1;
        end else if (launch) begin
            command_complete_flag_q <= 1'b0; // [RL11]
        end else if (buffer_empty_flag_q && !seq_active) begin
            command_complete_flag_q <= 1'b1; // [RL11]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            protection_violation_flag_q <= 1'b0;
        end else if (viol_set) begin
            protection_violation_flag_q <= 1'b1; // [RL13]
        end else if (wr_st && pwdata[fspg_pkg::ST_VIOL]) begin
            protection_violation_flag_q <= 1'b0; // [RL5]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            access_error_flag_q <= 1'b0;
        end else if (err_set) begin
            access_error_flag_q <= 1'b1; // [RL15]
        end else if (wr_st && pwdata[fspg_pkg::ST_ERR]) begin
            access_error_flag_q <= 1'b0; // [RL5]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            blank_q <= 1'b0;
        end else if (verify_blank) begin
            blank_q <= 1'b1; // [RL17]
        end else if (launch) begin
            blank_q <= 1'b0; // [RL17]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            fail_q <= 1'b0;
        end else if (special_mode && verify_fail) begin
            fail_q <= 1'b1; // [RL18]
        end else if (special_mode && wr_st && pwdata[fspg_pkg::ST_FAIL]) begin
            fail_q <= 1'b0; // [RL6]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            buffer_empty_irq_enable_q <= 1'b0;
            complete_irq_enable_q     <= 1'b0;
        end else if (wr_cfg && seq_q == fspg_pkg::SQ_IDLE) begin
            buffer_empty_irq_enable_q <= pwdata[fspg_pkg::CF_BEIE];
            complete_irq_enable_q     <= pwdata[fspg_pkg::CF_COMPLETE_IRQ_ENABLE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clock_divider_register_q <= fspg_pkg::CLKDIV_RST;
            div_loaded_q             <= 1'b0;
        end else if (wr_div && seq_q == fspg_pkg::SQ_IDLE) begin
            clock_divider_register_q <= pwdata[7:0];
            div_loaded_q             <= 1'b1; // [RL22]
        end
    end

    // Sizes only move while their range is disabled
    always_comb begin
        prot_d = pwdata[7:0];
        if (!protection_register_q[fspg_pkg::PR_HDIS]) begin
            prot_d[fspg_pkg::PR_HSZ +: 2] =
                protection_register_q[fspg_pkg::PR_HSZ +: 2];
        end
        if (!protection_register_q[fspg_pkg::PR_LDIS]) begin
            prot_d[fspg_pkg::PR_LSZ +: 2] =
                protection_register_q[fspg_pkg::PR_LSZ +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            protection_register_q <= fspg_pkg::PROT_RST;
        end else if (wr_prot && prot_ok && seq_q == fspg_pkg::SQ_IDLE) begin
            protection_register_q <= prot_d; // [RL1] [RL2] [RL23]
        end
    end
    assign prot_active = protection_register_q; // [RL3]

    assign irq = (buffer_empty_flag_q && buffer_empty_irq_enable_q) // [RL10]
              || (command_complete_flag_q && complete_irq_enable_q); // [RL12]

    assign done = special_mode && !seq_active; // [RL19]
    always_comb begin
        status_rd = 8'h00; // [RL5]
        status_rd[fspg_pkg::ST_EMPTY] = buffer_empty_flag_q;
        status_rd[fspg_pkg::ST_CMPL]  = command_complete_flag_q;
        status_rd[fspg_pkg::ST_VIOL]  = protection_violation_flag_q;
        status_rd[fspg_pkg::ST_ERR]   = access_error_flag_q;
        status_rd[fspg_pkg::ST_BLANK] = blank_q;
        status_rd[fspg_pkg::ST_FAIL]  = special_mode && fail_q; // [RL6]
        status_rd[fspg_pkg::ST_DONE]  = done; // [RL19]
    end

    // Read data latched in the setup phase, zero wait states
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (!map_ok) begin
                prdata_q <= 32'h0000_0000;
            end else if (idx == fspg_pkg::IDX_CLKDIV) begin
                prdata_q <= {24'h00_0000, clock_divider_register_q};
            end else if (idx == fspg_pkg::IDX_CONFIG) begin
                prdata_q <= {24'h00_0000, buffer_empty_irq_enable_q,
                             complete_irq_enable_q, 6'h00};
            end else if (idx == fspg_pkg::IDX_PROT) begin
                prdata_q <= {24'h00_0000, protection_register_q}; // [RL3]
            end else if (idx == fspg_pkg::IDX_STATUS) begin
                prdata_q <= {24'h00_0000, status_rd};
            end else if (idx == fspg_pkg::IDX_COMMAND) begin
                prdata_q <= {24'h00_0000, buf_q.code};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    chk_prot_hold: assert property ( // [RL2]
        @(posedge core_clk) disable iff (!reset_n)
        wr_prot && !prot_ok |=> $stable(protection_register_q))
        else $error("Disallowed protection write changed the register");

    chk_prot_scen: assert property ( // [RL1]
        @(posedge core_clk) disable iff (!reset_n)
        $changed(protection_register_q) |->
        fspg_pkg::SCN_ALLOW
            [{$past(protection_register_q[fspg_pkg::PR_OPEN]),
              $past(protection_register_q[fspg_pkg::PR_HDIS]),
              $past(protection_register_q[fspg_pkg::PR_LDIS])}]
            [{protection_register_q[fspg_pkg::PR_OPEN],
              protection_register_q[fspg_pkg::PR_HDIS],
              protection_register_q[fspg_pkg::PR_LDIS]}])
        else $error("Protection moved along a forbidden transition");

    chk_viol_block: assert property ( // [RL14]
        @(posedge core_clk) disable iff (!reset_n)
        protection_violation_flag_q |-> !launch)
        else $error("Launch while violation flag set");

    chk_err_block: assert property ( // [RL16]
        @(posedge core_clk) disable iff (!reset_n)
        access_error_flag_q |-> !launch)
        else $error("Launch while access error set");

    chk_empty_clear: assert property ( // [RL8]
        @(posedge core_clk) disable iff (!reset_n)
        launch && !seq_take |=>
        !buffer_empty_flag_q && launch_cmd.code != 8'h00)
        else $error("Launch did not clear buffer empty");

    chk_cmpl_empty: assert property ( // [RL11]
        @(posedge core_clk) disable iff (!reset_n)
        !buffer_empty_flag_q |-> !command_complete_flag_q)
        else $error("Complete set while buffer full");

    chk_abort_err: assert property ( // [RL9]
        @(posedge core_clk) disable iff (!reset_n)
        wr_st && !pwdata[ST_EMPTY_B] && seq_q != fspg_pkg::SQ_IDLE |=>
        access_error_flag_q && seq_q == fspg_pkg::SQ_IDLE)
        else $error("Abort did not set access error");

    chk_bad_code: assert property ( // [RL21]
        @(posedge core_clk) disable iff (!reset_n)
        wr_cmd && !code_ok |=> access_error_flag_q)
        else $error("Illegal command code accepted");

    chk_div_needed: assert property ( // [RL22]
        @(posedge core_clk) disable iff (!reset_n)
        go && !blocked && !div_loaded_q |=>
        access_error_flag_q && buffer_empty_flag_q)
        else $error("Command ran without divider setup");

    chk_fail_set: assert property ( // [RL18]
        @(posedge core_clk) disable iff (!reset_n)
        special_mode && verify_fail |=> fail_q ##0 !launch)
        else $error("Failing verify not flagged");

    chk_stop_err: assert property ( // [RL15]
        @(posedge core_clk) disable iff (!reset_n)
        cpu_stop && !command_complete_flag_q |=> access_error_flag_q)
        else $error("Stop during command not flagged");
endmodule : fspg_top

// [core/fspg_pkg.sv]
// Constants, types and tables of the flash status and protection guard.
// Assumes an 8-bit register per APB word and a synchronous core clock.
// Notes on behaviour
// [RL1] Protection may only be added; a write removing protection never lands.
// [RL2] A disallowed protection write is dropped whole; register keeps old value.
// [RL3] Protection register read returns the scenario actually in force.
// [RL4] From scenario 7 any target allowed; from 6 only 1, 3, 4, 6.
// [RL5] Normal modes: empty, violation, error writable; complete, blank read-only.
// [RL6] Special modes: fail is read/write, done is read-only.
// [RL7] Software clears fail before starting a new sequence in special modes.
// [RL8] Bit 7 buffer empty: reads 1 when buffers free; write 1 clears.
// [RL9] Writing 0 to bit 7 mid-sequence aborts and sets access error.
// [RL10] Interrupt when buffer empty and its enable are both set.
// [RL11] Bit 6 complete clears with empty; sets only when all work done.
// [RL12] Interrupt when command complete and its enable are both set.
// [RL13] Bit 5 violation sets on program or erase of protected area.
// [RL14] No command launches while the violation flag is set.
// [RL15] Bit 4 error sets on sequence fault, bad code, stop while busy.
// [RL16] No command launches while the access error flag is set.
// [RL17] Bit 2 blank sets on passing verify, clears on valid launch.
// [RL18] Special modes: bit 1 fail sets on failing verify; blocks launch.
// [RL19] Special modes: bit 0 done reads 0 while an operation runs.
// [RL20] Software writes flash address, then command, then 1 to launch.
// [RL21] Only codes 05, 20, 40, 41 accepted; others set access error.
// [RL22] Without a divider write since reset, launch sets access error.
// [RL23] Scenario from open and disable bits, checked against transition table.
package fspg_pkg;

    localparam logic [3:0] IDX_CLKDIV  = 4'h0;
    localparam logic [3:0] IDX_CONFIG  = 4'h3;
    localparam logic [3:0] IDX_PROT    = 4'h4;
    localparam logic [3:0] IDX_STATUS  = 4'h5;
    localparam logic [3:0] IDX_COMMAND = 4'h6;

    localparam int ST_EMPTY = 7;
    localparam int ST_CMPL  = 6;
    localparam int ST_VIOL  = 5;
    localparam int ST_ERR   = 4;
    localparam int ST_BLANK = 2;
    localparam int ST_FAIL  = 1;
    localparam int ST_DONE  = 0;

    localparam int CF_BEIE = 7;
    localparam int CF_COMPLETE_IRQ_ENABLE = 6;

    localparam int PR_OPEN = 7;
    localparam int PR_HDIS = 5;
    localparam int PR_HSZ  = 3;
    localparam int PR_LDIS = 2;
    localparam int PR_LSZ  = 0;

    localparam logic [7:0] CMD_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROG   = 8'h20;
    localparam logic [7:0] CMD_SECT   = 8'h40;
    localparam logic [7:0] CMD_MASS   = 8'h41;

    localparam logic [7:0] CLKDIV_RST = 8'h00;
    localparam logic [7:0] PROT_RST   = 8'hFF;

    // Row = from scenario, bit = to scenario
    localparam logic [7:0][7:0] SCN_ALLOW = {8'hFF, 8'h5A, 8'h20, 8'h10,
                                             8'h08, 8'h04, 8'h02, 8'h01};

    localparam logic [15:0] LO_BASE = 16'h4000;
    localparam logic [3:0][15:0] LO_END  = {16'h5FFF, 16'h4FFF,
                                            16'h47FF, 16'h43FF};
    localparam logic [3:0][15:0] HI_BASE = {16'hC000, 16'hE000,
                                            16'hF000, 16'hF800};

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] addr;
        logic [15:0] data;
    } fspg_cmd_t;

    typedef enum logic [1:0] {SQ_IDLE, SQ_ADDR, SQ_CMD} fspg_seq_t;

endpackage : fspg_pkg

// [core/fspg_prot_check.sv]
// Protection scenario transition check and protected-address test.
// Assumes protection bytes laid out as in the package field positions.
`timescale 1ns/1ns
module fspg_prot_check (
    input  wire logic [7:0]  cur,
    input  wire logic [7:0]  req,
    input  wire logic [15:0] addr,
    output logic             allow,
    output logic             hit
);
    logic [2:0] scn_cur;
    logic [2:0] scn_req;
    logic       in_hi;
    logic       in_lo;
    logic       sel;

    // Scenario number from open and disable bits [RL23]
    assign scn_cur = {cur[fspg_pkg::PR_OPEN], cur[fspg_pkg::PR_HDIS],
                      cur[fspg_pkg::PR_LDIS]};
    assign scn_req = {req[fspg_pkg::PR_OPEN], req[fspg_pkg::PR_HDIS],
                      req[fspg_pkg::PR_LDIS]};
    assign allow = fspg_pkg::SCN_ALLOW[scn_cur][scn_req]; // [RL4] [RL23]

    assign in_hi = addr >= fspg_pkg::HI_BASE[cur[fspg_pkg::PR_HSZ +: 2]];
    assign in_lo = (addr >= fspg_pkg::LO_BASE)
                 && (addr <= fspg_pkg::LO_END[cur[fspg_pkg::PR_LSZ +: 2]]);
    assign sel = (!cur[fspg_pkg::PR_HDIS] && in_hi)
               || (!cur[fspg_pkg::PR_LDIS] && in_lo);
    // Open selects protected ranges, closed selects unprotected ones
    assign hit = cur[fspg_pkg::PR_OPEN] ? sel : !sel;
endmodule : fspg_prot_check

// [dv/fspg_seq_model.sv]
// Behavioural model of the program and erase sequencer beyond the guard.
// Assumes one launch at a time; the verify outcome is set by blank_ok.
`timescale 1ns/1ns
module fspg_seq_model #(
    parameter int DLY = 6
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       launch,
    input  wire logic [7:0] code,
    input  wire logic       blank_ok,
    output logic            seq_take,
    output logic            seq_active,
    output logic            verify_blank,
    output logic            verify_fail
);
    int   cnt;
    logic vfy;

    // Busy from launch; buffer taken midway; verify result at the end
    always_ff @(posedge core_clk) begin
        seq_take     <= 1'b0;
        verify_blank <= 1'b0;
        verify_fail  <= 1'b0;
        if (!reset_n) begin
            cnt        <= 0;
            seq_active <= 1'b0;
            vfy        <= 1'b0;
        end else if (launch) begin
            cnt        <= 1;
            seq_active <= 1'b1;
            vfy        <= (code == fspg_pkg::CMD_VERIFY);
        end else if (cnt != 0) begin
            cnt <= cnt + 1;
            if (cnt == DLY) seq_take <= 1'b1;
            if (cnt == 2 * DLY) begin
                cnt          <= 0;
                seq_active   <= 1'b0;
                verify_blank <= vfy & blank_ok;
                verify_fail  <= vfy & ~blank_ok;
            end
        end
    end
endmodule : fspg_seq_model

// [dv/tb_flash_status_and_protection_guard.sv]
// Self-checking bench of the flash status and protection guard.
// Assumes the sequencer model answers every launch it sees.
`timescale 1ns/1ns
module tb_flash_status_and_protection_guard;
    localparam logic [7:0] DIV = {2'b00, fspg_pkg::IDX_CLKDIV, 2'b00};
    localparam logic [7:0] CFG = {2'b00, fspg_pkg::IDX_CONFIG, 2'b00};
    localparam logic [7:0] PRT = {2'b00, fspg_pkg::IDX_PROT, 2'b00};
    localparam logic [7:0] STA = {2'b00, fspg_pkg::IDX_STATUS, 2'b00};
    localparam logic [7:0] CMD = {2'b00, fspg_pkg::IDX_COMMAND, 2'b00};
    logic        core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, special_mode = 1'b0;
    logic        flash_wr = 1'b0, cpu_stop = 1'b0, blank_ok = 1'b1;
    logic [7:0]  paddr = 8'h00, q, prot_active;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] flash_addr = 16'h0, flash_data = 16'h0;
    logic        pready, pslverr, seq_take, seq_active, verify_blank;
    logic        verify_fail, launch, irq, lseen;
    fspg_pkg::fspg_cmd_t launch_cmd;
    int          fails = 0, checks = 0;
    // Rows: reset first, protection write, expected protection
    logic [16:0] prow [13] = '{17'h1FBFB, 17'h0DFFB, 17'h0FFFB, 17'h0DBDB,
        17'h0FBDB, 17'h0C3DB, 17'h1FBFB, 17'h05F5F, 17'h1FBFB, 17'h07F7F,
        17'h15B5B, 17'h0FF5B, 17'h1E7E7};

    fspg_top fspg_top_inst (.core_clk(core_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .special_mode(special_mode),
        .flash_wr(flash_wr), .flash_addr(flash_addr),
        .flash_data(flash_data), .cpu_stop(cpu_stop), .seq_take(seq_take),
        .seq_active(seq_active), .verify_blank(verify_blank),
        .verify_fail(verify_fail), .launch(launch),
        .launch_cmd(launch_cmd), .prot_active(prot_active), .irq(irq));
    fspg_seq_model #(.DLY(6)) fspg_seq_model_inst (.core_clk(core_clk),
        .reset_n(reset_n), .launch(launch), .code(launch_cmd.code),
        .blank_ok(blank_ok), .seq_take(seq_take), .seq_active(seq_active),
        .verify_blank(verify_blank), .verify_fail(verify_fail));

    always #5 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // Launch pulse sampled mid access cycle, where it stands
        do begin
            @(negedge core_clk);
            lseen = launch;
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q       = prdata[7:0];
        chk("pslverr", 1'b0, pslverr);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, e);
        apb(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask : rdc

    task automatic seq(input logic [15:0] a, input logic [7:0] c);
        @(posedge core_clk);
        flash_wr   <= 1'b1;
        flash_addr <= a;
        flash_data <= 16'hA5C3;
        @(posedge core_clk);
        flash_wr   <= 1'b0;
        apb(1'b1, CMD, c);
        apb(1'b1, STA, 8'h80);
    endtask : seq

    task automatic waitc;
        int n;
        n = 0;
        do begin
            apb(1'b0, STA, 8'h00);
            n++;
        end while (q[6] !== 1'b1 && n < 50);
    endtask : waitc

    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #500000;
        fails++;
        tally_and_finish;
    end

    initial begin
        foreach (prow[i]) begin
            if (prow[i][16]) do_reset;
            apb(1'b1, PRT, prow[i][15:8]);
            rdc("prot", PRT, prow[i][7:0]);
            chk("prot_active", prow[i][7:0], prot_active);
        end
        do_reset;
        rdc("status", STA, 8'hC0);
        chk("irq", 1'b0, irq);
        apb(1'b1, 8'h1C, 8'hFF);
        rdc("unmapped", 8'h1C, 8'h00);
        seq(16'h8000, fspg_pkg::CMD_PROG);
        chk("launch", 1'b0, lseen);
        rdc("status", STA, 8'hD0);
        apb(1'b1, STA, 8'h10);
        rdc("status", STA, 8'hC0);
        apb(1'b1, STA, 8'h00);
        rdc("status", STA, 8'hC0);
        apb(1'b1, DIV, 8'h04);
        apb(1'b1, CFG, 8'hC0);
        rdc("div", DIV, 8'h04);
        rdc("cfg", CFG, 8'hC0);
        @(negedge core_clk);
        chk("irq", 1'b1, irq);
        seq(16'h8000, 8'h11);
        rdc("status", STA, 8'hD0);
        seq(16'h8000, fspg_pkg::CMD_PROG);
        chk("launch", 1'b0, lseen);
        apb(1'b1, STA, 8'h10);
        seq(16'h8000, fspg_pkg::CMD_VERIFY);
        chk("launch", 1'b1, lseen);
        chk("code", fspg_pkg::CMD_VERIFY, launch_cmd.code);
        chk("addr", 16'h8000, launch_cmd.addr);
        chk("data", 16'hA5C3, launch_cmd.data);
        @(negedge core_clk);
        chk("irq", 1'b0, irq);
        rdc("status", STA, 8'h00);
        waitc;
        chk("status", 8'hC4, q);
        apb(1'b1, CFG, 8'h40);
        @(negedge core_clk);
        chk("irq", 1'b1, irq);
        apb(1'b1, STA, 8'h44);
        rdc("status", STA, 8'hC4);
        special_mode <= 1'b1;
        blank_ok     <= 1'b0;
        seq(16'h8000, fspg_pkg::CMD_VERIFY);
        rdc("status", STA, 8'h00);
        waitc;
        chk("status", 8'hC3, q);
        seq(16'h8000, fspg_pkg::CMD_PROG);
        chk("launch", 1'b0, lseen);
        apb(1'b1, STA, 8'h03);
        rdc("status", STA, 8'hC1);
        special_mode <= 1'b0;
        rdc("status", STA, 8'hC0);
        seq(16'h8000, fspg_pkg::CMD_MASS);
        chk("launch", 1'b1, lseen);
        waitc;
        apb(1'b1, PRT, 8'hDB);
        seq(16'hC000, fspg_pkg::CMD_PROG);
        rdc("status", STA, 8'hE0);
        seq(16'h8000, fspg_pkg::CMD_PROG);
        chk("launch", 1'b0, lseen);
        apb(1'b1, STA, 8'h20);
        seq(16'h8000, fspg_pkg::CMD_SECT);
        chk("launch", 1'b1, lseen);
        @(posedge core_clk);
        cpu_stop <= 1'b1;
        @(posedge core_clk);
        cpu_stop <= 1'b0;
        waitc;
        chk("status", 8'hD0, q);
        apb(1'b1, STA, 8'h10);
        // Zero to bit 7 after the flash write aborts the sequence
        @(posedge core_clk);
        flash_wr <= 1'b1;
        @(posedge core_clk);
        flash_wr <= 1'b0;
        apb(1'b1, STA, 8'h00);
        rdc("abort", STA, 8'hD0);
        apb(1'b1, STA, 8'h10);
        apb(1'b1, PRT, 8'hFF);
        rdc("prot", PRT, 8'hDB);
        tally_and_finish;
    end
endmodule : tb_flash_status_and_protection_guard
